//--- macu_unit.sv
// Multiply-accumulate unit with carry-select ALU and data RAM pointer.
// Assumes the core drives register strobes one cycle long, synchronous.
`timescale 1ns/1ns
// Function
// - Carry used only with version select set
// - Subtract is operand minus accumulator
// - Add includes carry when both selects set
// - Subtract removes inverted carry when selected
// - Product of accumulator and multiplicand, 24 bits
// - Low result byte is product bits 7:0
// - Middle result byte is bits 15:8
// - Version zero: multiplicand, pointer only on indirect steps, resets zero
// - Version one: multiplicand is also RAM address
// - Access auto-advance only with version one
// - Window read returns byte then advances
// - Indirect step accumulates RAM byte, advances pointer
// - Phase clock on port C pin zero, version one only
// - Mode field picks plain, add, subtract
// - High result byte is bits 23:16
// - Indirect pointer increments by one per step
// - Carry include select is write only
module macu_unit
    import macu_pkg::*;
#(
    parameter int RAM_AW = 8               // Data RAM address width
)(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              clkEn,
    input  wire logic [3:0]        regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [7:0]        regRdata,
    input  wire logic [7:0]        accIn,
    input  wire logic              mulStep,
    input  wire logic              aluGo,
    input  wire logic              aluSub,
    input  wire logic [7:0]        aluOperand,
    input  wire logic              carryFlag,
    output logic      [7:0]        aluResult,
    output logic                   aluCarry,
    output logic      [RAM_AW-1:0] ramAddr,
    output logic                   ramWe,
    output logic      [7:0]        ramWdata,
    input  wire logic [7:0]        ramRdata,
    output logic                   pcPin0Out,
    output logic                   pcPin0Sel
);
    // Register state
    logic [7:0]  ctrl;          // Control, bit 7 stored but hidden
    logic [7:0]  multiplicand_bits;          // Multiplicand or pointer
    logic [7:0]  legacyAddr;    // Address register for version zero
    logic [23:0] acc;           // Product accumulator
    logic [7:0]  opt;           // Display and option control
    logic        phase;         // Phase clock divider output
    logic        rdPend;        // Read data cycle marker
    logic [7:0]  rdData;        // Registered read data

    macu_op_if op ();
    macu_mult u_mult (.op(op));

    // Decoded option and control bits
    wire version_select   = opt[MACU_OPT_VSEL];
    wire phoSel   = opt[MACU_OPT_PHO];
    wire insSel   = ctrl[MACU_CTRL_INS];
    wire plusEn   = ctrl[MACU_CTRL_PLUS];
    wire indrEn   = ctrl[MACU_CTRL_INDIRECT_POINTER_ENABLE];

    // Address decoding
    wire selCtrl  = (regAddr == MACU_OFF_CTRL);
    wire selMuly  = (regAddr == MACU_OFF_MULTIPLICAND_BITS);
    wire selLow   = (regAddr == MACU_OFF_PLOW);
    wire selMid   = (regAddr == MACU_OFF_PMID);
    wire selHigh  = (regAddr == MACU_OFF_PHIGH);
    wire selOpt   = (regAddr == MACU_OFF_OPT);
    wire selLaddr = (regAddr == MACU_OFF_LADDR);
    wire selRam   = (regAddr == MACU_OFF_RAMW);

    // Data RAM address source follows version select; an indirect step
    // in version zero still fetches Y through the multiplicand pointer
    wire       yAddrSel = version_select | (indrEn & mulStep);
    wire [7:0] ramPtr   = yAddrSel ? multiplicand_bits : legacyAddr;
    assign ramAddr  = ramPtr[RAM_AW-1:0];
    assign ramWe    = clkEn & regWr & selRam;
    assign ramWdata = regWdata;

    // Indirect mode fetches Y through the RAM window
    wire       indirect = indrEn;
    wire [7:0] yVal     = indirect ? ramRdata : multiplicand_bits;
    wire       ptrStep  = mulStep & indrEn & plusEn;
    wire       winAcc   = (regWr | regRd) & selRam;
    wire       winStep  = winAcc & version_select;

    assign op.xOp  = accIn;
    assign op.yOp  = yVal;
    assign op.mode = ctrl[3:0];
    assign op.acc  = acc;

    // ALU with carry gated by version select
    wire useCarry = version_select & insSel;
    macu_alu_op_t aluOp;
    assign aluOp = !aluGo ? MACU_ALU_NOP :
                   aluSub ? MACU_ALU_SUB : MACU_ALU_ADD;
    macu_alu u_alu (
        .accVal   (accIn),
        .operand  (aluOperand),
        .aluOp    (aluOp),
        .carryIn  (carryFlag),
        .useCarry (useCarry),
        .aluOut   (aluResult),
        .carryOut (aluCarry)
    );

    // Read multiplexer; carry include bit reads as zero
    wire [7:0] rdMux =
        selCtrl  ? {1'b0, ctrl[6:0]} :
        selMuly  ? multiplicand_bits :
        selLow   ? acc[7:0] :
        selMid   ? acc[15:8] :
        selHigh  ? acc[23:16] :
        selOpt   ? opt :
        selLaddr ? legacyAddr :
        selRam   ? ramRdata : MACU_RST_BYTE;

    // Next multiplicand / pointer value
    wire [7:0] next_multiplicand_bits =
        (regWr & selMuly) ? regWdata :
        (ptrStep | winStep) ? multiplicand_bits + 8'h01 : multiplicand_bits;

    // Next accumulator value
    wire [23:0] next_acc =
        (regWr & selLow)  ? {acc[23:8], regWdata} :
        (regWr & selMid)  ? {acc[23:16], regWdata, acc[7:0]} :
        (regWr & selHigh) ? {regWdata, acc[15:0]} :
        (mulStep & op.modeOk) ? op.result : acc;

    // Control and option registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= MACU_RST_BYTE;
            opt  <= MACU_OPT_RST;
        end else if (clkEn) begin
            if (regWr && selCtrl) begin
                ctrl <= regWdata & 8'hBF;
            end
            if (regWr && selOpt) begin
                opt <= regWdata;
            end
        end
    end

    // Multiplicand, legacy address and accumulator
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            multiplicand_bits       <= MACU_RST_BYTE;
            legacyAddr <= MACU_RST_BYTE;
            acc        <= '0;
        end else if (clkEn) begin
            multiplicand_bits <= next_multiplicand_bits;
            acc  <= next_acc;
            if (regWr && selLaddr) begin
                legacyAddr <= regWdata;
            end
        end
    end

    // Read data held for the cycle after the strobe
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= MACU_RST_BYTE;
            rdPend <= 1'b0;
        end else if (clkEn) begin
            rdPend <= regRd;
            rdData <= regRd ? rdMux : MACU_RST_BYTE;
        end
    end
    assign regRdata = rdData;

    // Phase clock: core clock divided by two
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 1'b0;
        end else if (clkEn) begin
            phase <= ~phase;
        end
    end
    assign pcPin0Sel = phoSel & version_select;
    assign pcPin0Out = pcPin0Sel & phase;

    // Checks
    // Pointer step with no software write to the pointer beside it
    sequence ptrStepSeq;
        clkEn && ptrStep && !(regWr && selMuly);
    endsequence

    // Window access while the multiplicand doubles as RAM address
    sequence winAccSeq;
        clkEn && version_select && selRam && (regWr || regRd);
    endsequence

    // Pointer moves by exactly one per indirect step
    ptr_incr_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        ptrStepSeq |=> multiplicand_bits == $past(multiplicand_bits) + 8'h01)
        else $error("pointer did not advance by one");

    // Window access walks the pointer forward by one
    win_step_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        winAccSeq |=> multiplicand_bits == $past(multiplicand_bits) + 8'h01)
        else $error("window access did not advance pointer");

    // Version zero leaves the multiplicand alone unless stepped
    legacy_hold_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && !version_select && !ptrStep && !(regWr && selMuly))
        |=> multiplicand_bits == $past(multiplicand_bits))
        else $error("multiplicand moved without version one");

    // Indirect step fetches Y at the pointer in either version
    indir_addr_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && mulStep && indrEn) |-> ramAddr == multiplicand_bits[RAM_AW-1:0])
        else $error("indirect step used wrong address");

    // Plain add with version zero ignores the carry
    carry_gate_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (aluGo && !aluSub && !version_select) |->
        aluResult == 8'(accIn + aluOperand))
        else $error("carry added with version zero");

    // Subtract takes the accumulator from the operand
    sub_order_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (aluGo && aluSub && !useCarry) |->
        aluResult == 8'(aluOperand - accIn))
        else $error("subtract order wrong");

    // Add with both selects takes the carry in
    add_carry_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (aluGo && !aluSub && useCarry) |->
        aluResult == 8'(accIn + aluOperand + {7'h00, carryFlag}))
        else $error("carry not added");

    // Subtract with both selects removes the inverted carry
    sub_borrow_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (aluGo && aluSub && useCarry) |->
        aluResult == 8'(aluOperand - accIn - {7'h00, ~carryFlag}))
        else $error("borrow not subtracted");

    // Carry include bit never reads back
    ins_hidden_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && regRd && selCtrl) |=> !regRdata[7])
        else $error("carry include bit read back");

    // Result bytes read back the accumulator slices
    low_read_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && regRd && selLow) |=> regRdata == $past(acc[7:0]))
        else $error("low result byte wrong");
    mid_read_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && regRd && selMid) |=> regRdata == $past(acc[15:8]))
        else $error("middle result byte wrong");
    high_read_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && regRd && selHigh) |=> regRdata == $past(acc[23:16]))
        else $error("high result byte wrong");

    // Read data stands only in the cycle after the strobe
    rdata_idle_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !rdPend |-> regRdata == MACU_RST_BYTE)
        else $error("read data left standing");

    // Plain mode loads the product
    plain_mul_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && mulStep && ctrl[3:2] == MACU_MODE_PLAIN && !regWr) |=>
        acc == $past(op.result))
        else $error("plain product not loaded");

    // Unused modes leave the accumulator as it was
    mode_hold_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && mulStep && ctrl[3:2] == 2'b01 && !regWr) |=>
        acc == $past(acc))
        else $error("unused mode changed result");

    // Software result write loads the low byte directly
    res_write_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && regWr && selLow) |=> acc[7:0] == $past(regWdata))
        else $error("result byte write not loaded");

    // Without a step or a write the result holds
    acc_hold_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (clkEn && !mulStep && !regWr) |=> acc == $past(acc))
        else $error("result moved without a step");

    // Clock enable low freezes result, multiplicand, control and option registers
    freeze_hold_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !clkEn |=> acc == $past(acc) && multiplicand_bits == $past(multiplicand_bits) &&
        ctrl == $past(ctrl) && opt == $past(opt))
        else $error("state moved with clock enable low");

    // Bit six of the control register never sets
    ctrl_bit6_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !ctrl[6])
        else $error("undefined control bit set");

    // Phase clock toggles on every enabled edge
    phase_toggle_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clkEn |=> phase != $past(phase))
        else $error("phase clock did not toggle");

    // Phase clock never reaches the pin unless selected
    phase_out_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !pcPin0Sel |-> !pcPin0Out)
        else $error("phase clock leaked to pin");
endmodule : macu_unit

//--- macu_pkg.sv
// Package for the multiply-accumulate unit with carry select.
// Assumes a single core clock; register bus is a plain strobe port.
package macu_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] MACU_OFF_CTRL  = 4'h0; // Multiplier control
    localparam logic [3:0] MACU_OFF_MULTIPLICAND_BITS  = 4'h1; // Multiplicand / pointer
    localparam logic [3:0] MACU_OFF_PLOW  = 4'h2; // Product bits 7:0
    localparam logic [3:0] MACU_OFF_PMID  = 4'h3; // Product bits 15:8
    localparam logic [3:0] MACU_OFF_PHIGH = 4'h4; // Product bits 23:16
    localparam logic [3:0] MACU_OFF_OPT   = 4'h5; // Display/option control
    localparam logic [3:0] MACU_OFF_LADDR = 4'h6; // Legacy RAM address
    localparam logic [3:0] MACU_OFF_RAMW  = 4'h7; // Data RAM window
    // Control register fields
    localparam int MACU_CTRL_INS  = 7; // Carry include select, write only
    localparam int MACU_CTRL_INDIRECT_POINTER_ENABLE = 5; // Indirect pointer enable
    localparam int MACU_CTRL_PLUS = 4; // Auto-increment enable
    // Option register fields
    localparam int MACU_OPT_VSEL = 6;  // Version select
    localparam int MACU_OPT_PHO  = 5;  // Phase clock out select
    localparam int MACU_OPT_ONE  = 4;  // Bit that reads as written
    // Reset values
    localparam logic [7:0] MACU_RST_BYTE = 8'h00;
    localparam logic [7:0] MACU_OPT_RST  = 8'h10;
    // Mode field top bits
    localparam logic [1:0] MACU_MODE_PLAIN = 2'b00;
    localparam logic [1:0] MACU_MODE_ADD   = 2'b10;
    localparam logic [1:0] MACU_MODE_SUB   = 2'b11;
    // Phase clock divider half period in core cycles
    localparam int MACU_PH_HALF = 1;
    // ALU operations
    typedef enum logic [1:0] {
        MACU_ALU_ADD = 2'b00,
        MACU_ALU_SUB = 2'b01,
        MACU_ALU_NOP = 2'b10
    } macu_alu_op_t;
endpackage : macu_pkg

//--- macu_op_if.sv
// Interface carrying multiplier operands and result between modules.
// Assumes both ends share core_clk.
`timescale 1ns/1ns
interface macu_op_if;
    logic [7:0]  xOp;      // Accumulator operand
    logic [7:0]  yOp;      // Multiplicand operand
    logic [3:0]  mode;     // Multiply mode field
    logic [23:0] acc;      // Current accumulated value
    logic [23:0] result;   // Next accumulated value
    logic        modeOk;   // Mode is defined
    modport core (output xOp, yOp, mode, acc, input result, modeOk);
    modport mult (input xOp, yOp, mode, acc, output result, modeOk);
endinterface : macu_op_if

//--- macu_mult.sv
// Combinational 8x8 signed/unsigned multiply with accumulate.
// Assumes operands are stable while the core samples the result.
`timescale 1ns/1ns
module macu_mult
    import macu_pkg::*;
(
    macu_op_if.mult op
);
    wire        xSigned = ~op.mode[1];       // Low bits pick signedness
    wire        ySigned = ~op.mode[0];
    wire [23:0] xExt    = {{16{xSigned & op.xOp[7]}}, op.xOp};
    wire [23:0] yExt    = {{16{ySigned & op.yOp[7]}}, op.yOp};
    wire [47:0] prodW   = xExt * yExt;
    wire [23:0] prod    = prodW[23:0];       // 24-bit product
    wire [1:0]  top     = op.mode[3:2];

    // Mode selection of plain, add and subtract forms
    assign op.modeOk = (top != 2'b01);
    assign op.result = (top == MACU_MODE_ADD) ? op.acc + prod :
                       (top == MACU_MODE_SUB) ? op.acc - prod :
                       (top == MACU_MODE_PLAIN) ? prod : op.acc;
endmodule : macu_mult

//--- macu_alu.sv
// Add/subtract datapath with optional carry in.
// Assumes carry flag is supplied by the core status register.
`timescale 1ns/1ns
module macu_alu
    import macu_pkg::*;
(
    input  wire logic [7:0]   accVal,
    input  wire logic [7:0]   operand,
    input  wire macu_alu_op_t aluOp,
    input  wire logic         carryIn,
    input  wire logic         useCarry,
    output logic      [7:0]   aluOut,
    output logic              carryOut
);
    wire [8:0] cin   = {8'h00, useCarry & carryIn};
    wire [8:0] bor   = {8'h00, useCarry & ~carryIn};
    wire [8:0] sum   = {1'b0, accVal} + {1'b0, operand} + cin;
    wire [8:0] diff  = {1'b0, operand} - {1'b0, accVal} - bor;
    // Carry flag: add carry out, subtract no-borrow
    assign aluOut   = (aluOp == MACU_ALU_SUB) ? diff[7:0] : sum[7:0];
    assign carryOut = (aluOp == MACU_ALU_SUB) ? ~diff[8] : sum[8];
endmodule : macu_alu

//--- macu_ram_model.sv
// Data RAM model on the far side of the unit's RAM port.
// Assumes writes land on a rising core_clk edge, reads are combinational.
`timescale 1ns/1ns
module macu_ram_model #(
    parameter int RAM_AW = 8                  // Address width
)(
    input  wire logic              core_clk,
    input  wire logic [RAM_AW-1:0] ramAddr,
    input  wire logic              ramWe,
    input  wire logic [7:0]        ramWdata,
    output logic      [7:0]        ramRdata
);
    logic [7:0] mem [2**RAM_AW];              // Storage array
    // Pattern fill with address XOR A5, so only the byte at address A5 starts at zero
    initial begin
        for (int i = 0; i < 2**RAM_AW; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end
    // Byte write on the strobe edge
    always @(posedge core_clk) begin
        if (ramWe) begin
            mem[ramAddr] <= ramWdata;
        end
    end
    // Read follows the address at once
    assign ramRdata = mem[ramAddr];
endmodule : macu_ram_model

//--- tb_top.sv
// Self-checking bench for the multiply-accumulate unit.
// Assumes a RAM model on the RAM port; clkEn dropped once for a freeze.
`timescale 1ns/1ns
module tb_top
    import macu_pkg::*;
;
    logic       core_clk, arst_n, clkEn, regWr, regRd, mulStep;
    logic       aluGo, aluSub, carryFlag, aluCarry, ramWe;
    logic       pcPin0Out, pcPin0Sel;
    logic [3:0] regAddr;                      // Register index
    logic [7:0] regWdata, regRdata, accIn, aluOperand, aluResult;
    logic [7:0] ramAddr, ramWdata, ramRdata;  // RAM port
    int         failCount, testsRun, cycles;  // Bench counters
    macu_unit #(.RAM_AW(8)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .accIn(accIn), .mulStep(mulStep), .aluGo(aluGo),
        .aluSub(aluSub), .aluOperand(aluOperand), .carryFlag(carryFlag),
        .aluResult(aluResult), .aluCarry(aluCarry), .ramAddr(ramAddr),
        .ramWe(ramWe), .ramWdata(ramWdata), .ramRdata(ramRdata),
        .pcPin0Out(pcPin0Out), .pcPin0Sel(pcPin0Sel));
    macu_ram_model #(.RAM_AW(8)) ram_u (.core_clk(core_clk),
        .ramAddr(ramAddr), .ramWe(ramWe), .ramWdata(ramWdata),
        .ramRdata(ramRdata));
    // Clock source
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Final report and end of run
    task automatic wrapUp();
        $display("Checks %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrapUp
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failCount++;
            wrapUp();
        end
    end
    // One comparison
    task automatic chk(input string what, input logic [23:0] e, g);
        testsRun++;
        if (g !== e) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Register write cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr
    // Register read cycle, data taken in the following cycle
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 chk($sformatf("reg %0d", a), e, regRdata);
    endtask : rc
    // Result bytes write and read
    task automatic wres(input logic [23:0] v);
        wr(MACU_OFF_PLOW, v[7:0]);
        wr(MACU_OFF_PMID, v[15:8]);
        wr(MACU_OFF_PHIGH, v[23:16]);
    endtask : wres
    task automatic rres(input logic [23:0] e);
        rc(MACU_OFF_PLOW, e[7:0]);
        rc(MACU_OFF_PMID, e[15:8]);
        rc(MACU_OFF_PHIGH, e[23:16]);
    endtask : rres
    // One multiply instruction
    task automatic step(input logic [7:0] x);
        @(posedge core_clk);
        mulStep <= 1'b1;
        accIn   <= x;
        @(posedge core_clk);
        mulStep <= 1'b0;
    endtask : step
    // Reset pulse of three cycles
    task automatic rstDut();
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
    endtask : rstDut
    // Expected accumulated value for a mode
    function automatic logic [23:0] mulExp(input logic [23:0] acc,
            input logic [7:0] x, y, input logic [3:0] m);
        logic [23:0] px, py, p;
        px = m[1] ? {16'h0000, x} : {{16{x[7]}}, x};
        py = m[0] ? {16'h0000, y} : {{16{y[7]}}, y};
        p  = px * py;
        case (m[3:2])
            2'b00:   return p;
            2'b10:   return acc + p;
            2'b11:   return acc - p;
            default: return acc;
        endcase
    endfunction : mulExp
    // Random add/subtract against the expected carry handling
    task automatic aluT(input logic vs, carry_include_select, input int n);
        logic [8:0] e;
        logic       cy;
        wr(MACU_OFF_CTRL, {carry_include_select, 7'h00});
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            aluGo      <= 1'b1;
            aluSub     <= i[0];
            accIn      <= (i < 4) ? 8'h01 : 8'($urandom);
            aluOperand <= (i < 4) ? 8'hFF : 8'($urandom);
            carryFlag  <= 1'($urandom);
            @(negedge core_clk);
            if (aluSub) begin
                e = {1'b0, aluOperand} - {1'b0, accIn}
                    - {8'h00, vs & carry_include_select & ~carryFlag};
                cy = ~e[8];
            end else begin
                e = {1'b0, accIn} + {1'b0, aluOperand}
                    + {8'h00, vs & carry_include_select & carryFlag};
                cy = e[8];
            end
            chk("alu result", e[7:0], aluResult);
            chk("alu carry", cy, aluCarry);
        end
        @(posedge core_clk);
        aluGo <= 1'b0;
    endtask : aluT
    // Main sequence
    initial begin
        logic [7:0]  x, y, sh [4];
        logic [23:0] pre, accM;
        logic        b;
        void'($urandom(32'h9897));
        {regWr, regRd, mulStep, aluGo, aluSub, carryFlag} = '0;
        {regAddr, regWdata, accIn, aluOperand} = '0;
        arst_n = 1'b0;
        clkEn  = 1'b1;
        rstDut();
        // Version zero: reset values, write-only bit, plain ALU, modes
        rc(MACU_OFF_MULTIPLICAND_BITS, MACU_RST_BYTE);
        rc(MACU_OFF_OPT, MACU_OPT_RST);
        rres(24'h00_0000);
        rc(4'hC, 8'h00);
        wr(MACU_OFF_OPT, 8'h30);
        @(negedge core_clk);
        chk("phase sel", 1'b0, pcPin0Sel);
        wr(MACU_OFF_CTRL, 8'hFF);
        rc(MACU_OFF_CTRL, 8'h3F);
        aluT(1'b0, 1'b1, 16);
        for (int i = 0; i < 32; i++) begin
            x   = (i < 16) ? 8'h80 : 8'($urandom);
            y   = (i < 16) ? 8'hFF : 8'($urandom);
            pre = 24'($urandom);
            wres(pre);
            wr(MACU_OFF_MULTIPLICAND_BITS, y);
            wr(MACU_OFF_CTRL, {4'h0, 4'(i)});
            step(x);
            accM = mulExp(pre, x, y, 4'(i));
            rres(accM);
        end
        wr(MACU_OFF_MULTIPLICAND_BITS, 8'h22);
        wr(MACU_OFF_LADDR, 8'h10);
        rc(MACU_OFF_RAMW, 8'h10 ^ 8'hA5);
        rc(MACU_OFF_RAMW, 8'h10 ^ 8'hA5);
        rc(MACU_OFF_MULTIPLICAND_BITS, 8'h22);
        $display("Test version zero done");
        // Version one: carry ALU, phase clock, window walk, indirect
        rstDut();
        wr(MACU_OFF_OPT, 8'h70);
        @(negedge core_clk);
        b = pcPin0Out;
        @(negedge core_clk);
        chk("phase sel", 1'b1, pcPin0Sel);
        chk("phase toggle", {~b}, pcPin0Out);
        aluT(1'b1, 1'b1, 16);
        aluT(1'b1, 1'b0, 8);
        wr(MACU_OFF_MULTIPLICAND_BITS, 8'h40);
        for (int i = 0; i < 4; i++) begin
            sh[i] = 8'($urandom);
            wr(MACU_OFF_RAMW, sh[i]);
        end
        rc(MACU_OFF_MULTIPLICAND_BITS, 8'h44);
        wr(MACU_OFF_MULTIPLICAND_BITS, 8'h40);
        for (int i = 0; i < 4; i++) begin
            rc(MACU_OFF_RAMW, sh[i]);
        end
        wr(MACU_OFF_CTRL, 8'h3B);
        wres(24'h00_0000);
        wr(MACU_OFF_MULTIPLICAND_BITS, 8'h40);
        accM = 24'h00_0000;
        for (int i = 0; i < 4; i++) begin
            step(8'h55);
            accM = accM + 24'h00_0055 * {16'h0000, sh[i]};
        end
        rres(accM);
        rc(MACU_OFF_MULTIPLICAND_BITS, 8'h44);
        // Clock enable low: a write must not land
        @(posedge core_clk);
        clkEn <= 1'b0;
        wr(MACU_OFF_MULTIPLICAND_BITS, 8'h99);
        clkEn <= 1'b1;
        rc(MACU_OFF_MULTIPLICAND_BITS, 8'h44);
        $display("Test version one done");
        wrapUp();
    end
endmodule : tb_top
